// *** logic/plcio_top.sv ***
// special register bank: analog i/o, pulse-train counter and pid operands
`timescale 1ns/1ps
`default_nettype none
`include "plcio_regs.svh"

// Contract
// RL1: three read-only analog input registers in 0.1% steps, always readable.
// RL2: analog registers exchange with terminals only at end of scan.
// RL3: four writable analog output registers drive their terminals.
// RL4: a terminal follows its register only when its source selection is 7.
// RL5: pulses per count cycle give a sample result of 0 to 32767.
// RL6: sample equals pulses times prescale times selected scaling factor.
// RL7: scaling select 0..5: none, x1, x0.1, x0.01, x0.001, x0.0001.
// RL8: prescale value 0 to 32767, reset to 1, used in sample.
// RL9: samples accumulate; low word 0 to 9999, separate high word.
// RL10: clear register 1 clears the pulse counts, 0 leaves them.
// RL11: pulses are counted only while the run register holds 1.
// RL12: pid select picks source and direction; odd forward, even reverse.
// RL13: selections 90 to 101 compute pid but do not drive frequency. Here only 90, 91, 100 and 101 do; 92 to 99 run no pid.
// RL14: target register means set point or deviation by pid select.
// RL15: target or deviation is signed -100..100% in 0.01% units.
// RL16: feedback is 0..100% in 0.01% units.
// RL17: deviation selections ignore the feedback register.
// RL18: pid result register is signed -100..100% in 0.01% units.
// RL19: pid run register 1 runs pid, 0 stops; replaces external enable.
// RL20: out-of-range pid operands act as the nearest range limit.
// RL21: stopped counting holds sample and total until restart or clear.
// RL22: registers are 16-bit words; writable ones reset to zero. Here the source word is 32 bits, pid select resets to 10 and prescale to 1.
module plcio_top #(
    parameter int unsigned CYCLE_CLKS = `PLCIO_CYCLE_CLKS
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire plcio_pkg::plcio_axi_req_t AXI_REQ_I,
    output plcio_pkg::plcio_axi_rsp_t AXI_RSP_O,
    input wire logic SCAN_END_I,
    input wire logic [15:0] AIN_A_I,
    input wire logic [15:0] AIN_B_I,
    input wire logic [15:0] AIN_C_I,
    input wire logic PULSE_PIN_I,
    input wire logic EXT_PID_EN_PIN_I,
    output logic [15:0] AOUT_METER_O,
    output logic [15:0] AOUT_MAIN_O,
    output logic [15:0] AOUT_OPT_A_O,
    output logic [15:0] AOUT_OPT_B_O,
    output logic [3:0] AOUT_PLC_O,
    output logic [15:0] PID_MV_O,
    output logic PID_RUN_O,
    output logic PID_APPLY_O
);
    import plcio_pkg::*;

    // merge a bus write into a 16-bit register through the low byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // signed clamp used for every percent operand and result
    function automatic logic signed [16:0] clamp17(input logic signed [17:0] x,
                                                   input logic signed [16:0] lo,
                                                   input logic signed [16:0] hi);
        if (x > 18'(hi)) clamp17 = hi;
        else if (x < 18'(lo)) clamp17 = lo;
        else clamp17 = 17'(x);
    endfunction : clamp17

    // pulses times prescale times decimal factor, saturated; select 0 and codes 6 and 7 give the pulses alone
    function automatic logic [15:0] scale(input logic [15:0] n,
                                          input logic [15:0] pre,
                                          input logic [2:0] sel);
        logic [30:0] prod;
        logic [30:0] q;
        prod = 31'(n) * 31'(pre[14:0]);
        case (sel)
            3'h1: q = prod;
            3'h2: q = prod / 31'h0000000a;
            3'h3: q = prod / 31'h00000064;
            3'h4: q = prod / 31'h000003e8;
            3'h5: q = prod / 31'h00002710;
            default: q = 31'(n);
        endcase
        scale = (q > 31'(`PLCIO_SAMPLE_MAX)) ? `PLCIO_SAMPLE_MAX : q[15:0];
    endfunction : scale

    // pid source from the action selection code
    function automatic plcio_pid_src_t pid_src(input logic [15:0] code);
        if (code == 16'h0046 || code == 16'h0047 ||
            code == 16'h005a || code == 16'h005b) pid_src = PLCIO_PID_DEV;
        else if (code == 16'h0050 || code == 16'h0051 ||
                 code == 16'h0064 || code == 16'h0065) pid_src = PLCIO_PID_SPPV;
        else pid_src = PLCIO_PID_EXT;
    endfunction : pid_src

    // ---------------- bus slave state ----------------
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic awready_q, wready_q, arready_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    // ---------------- register state ----------------
    logic [15:0] ain_q [3];
    logic [15:0] aout_q [4];
    logic [15:0] aterm_q [4];
    logic [3:0] aplc_q;
    logic [15:0] clear_q, run_q, target_q, feedbk_q, pidrun_q;
    logic [15:0] pidact_q, scale_q, presc_q, pidout_q;
    logic [31:0] outsrc_q;
    logic apply_q, pid_en_q;
    logic [15:0] cnt_q, sample_q;
    logic [31:0] total_q;
    logic [31:0] cyc_q;
    logic pls_s1_q, pls_s2_q, pls_s3_q, ext_s1_q, ext_s2_q;

    // handshake decode; address and data may arrive in either order
    wire aw_fire = AXI_REQ_I.awvalid & awready_q;
    wire w_fire = AXI_REQ_I.wvalid & wready_q;
    wire ar_fire = AXI_REQ_I.arvalid & arready_q;
    wire aw_ok = aw_have_q | aw_fire;
    wire w_ok = w_have_q | w_fire;
    wire do_write = aw_ok & w_ok;
    wire [7:0] wa = aw_have_q ? awaddr_q : AXI_REQ_I.awaddr;
    wire [31:0] wd = w_have_q ? wdata_q : AXI_REQ_I.wdata;
    wire [3:0] ws = w_have_q ? wstrb_q : AXI_REQ_I.wstrb;
    wire aw_have_d = aw_ok & ~do_write;
    wire w_have_d = w_ok & ~do_write;
    wire bvalid_d = do_write | (bvalid_q & ~AXI_REQ_I.bready);
    wire rvalid_d = ar_fire | (rvalid_q & ~AXI_REQ_I.rready);

    // write decode of each writable word
    wire we_clear = do_write && wa == `PLCIO_CLEAR_OFS;
    wire we_run = do_write && wa == `PLCIO_RUN_OFS;
    wire we_target = do_write && wa == `PLCIO_TARGET_OFS;
    wire we_feedbk = do_write && wa == `PLCIO_FEEDBK_OFS;
    wire we_pidrun = do_write && wa == `PLCIO_PIDRUN_OFS;
    wire we_pidact = do_write && wa == `PLCIO_PIDACT_OFS;
    wire we_scale = do_write && wa == `PLCIO_SCALE_OFS;
    wire we_presc = do_write && wa == `PLCIO_PRESC_OFS;
    wire we_outsrc = do_write && wa == `PLCIO_OUTSRC_OFS;
    wire we_aout = do_write && wa >= `PLCIO_AOUT_OFS &&
                   wa < `PLCIO_SAMPLE_OFS && wa[1:0] == 2'h0;
    wire [1:0] aout_idx = 2'((wa - `PLCIO_AOUT_OFS) >> 2);
    wire w_mapped = we_clear | we_run | we_target | we_feedbk | we_pidrun |
                    we_pidact | we_scale | we_presc | we_outsrc | we_aout;

    // pulse total split into decimal words
    wire [15:0] tot_lo = 16'(total_q % `PLCIO_LOW_MOD); // see RL9
    wire [15:0] tot_hi = 16'(total_q / `PLCIO_LOW_MOD); // see RL9

    // read decode; unmapped addresses answer with an error and zero data
    logic [15:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        if (AXI_REQ_I.araddr == `PLCIO_AIN_OFS) rd_word = ain_q[0]; // see RL1
        else if (AXI_REQ_I.araddr == 8'h04) rd_word = ain_q[1];
        else if (AXI_REQ_I.araddr == 8'h08) rd_word = ain_q[2];
        else if (AXI_REQ_I.araddr == `PLCIO_AOUT_OFS) rd_word = aout_q[0];
        else if (AXI_REQ_I.araddr == 8'h10) rd_word = aout_q[1];
        else if (AXI_REQ_I.araddr == 8'h14) rd_word = aout_q[2];
        else if (AXI_REQ_I.araddr == 8'h18) rd_word = aout_q[3];
        else if (AXI_REQ_I.araddr == `PLCIO_SAMPLE_OFS) rd_word = sample_q;
        else if (AXI_REQ_I.araddr == `PLCIO_TOT_LO_OFS) rd_word = tot_lo;
        else if (AXI_REQ_I.araddr == `PLCIO_TOT_HI_OFS) rd_word = tot_hi;
        else if (AXI_REQ_I.araddr == `PLCIO_CLEAR_OFS) rd_word = clear_q;
        else if (AXI_REQ_I.araddr == `PLCIO_RUN_OFS) rd_word = run_q;
        else if (AXI_REQ_I.araddr == `PLCIO_TARGET_OFS) rd_word = target_q;
        else if (AXI_REQ_I.araddr == `PLCIO_FEEDBK_OFS) rd_word = feedbk_q;
        else if (AXI_REQ_I.araddr == `PLCIO_PIDOUT_OFS) rd_word = pidout_q;
        else if (AXI_REQ_I.araddr == `PLCIO_PIDRUN_OFS) rd_word = pidrun_q;
        else if (AXI_REQ_I.araddr == `PLCIO_PIDACT_OFS) rd_word = pidact_q;
        else if (AXI_REQ_I.araddr == `PLCIO_SCALE_OFS) rd_word = scale_q;
        else if (AXI_REQ_I.araddr == `PLCIO_PRESC_OFS) rd_word = presc_q;
        else if (AXI_REQ_I.araddr == `PLCIO_OUTSRC_OFS) rd_word = 16'h0000;
        else rd_hit = 1'b0;
    end
    // the source word is the only full 32-bit register
    wire [31:0] rd_data = (AXI_REQ_I.araddr == `PLCIO_OUTSRC_OFS) ?
                          outsrc_q : {16'h0000, rd_word};

    // bus handshake registers; readies drop while an answer waits
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= `PLCIO_RESP_OK;
            rresp_q <= `PLCIO_RESP_OK;
            rdata_q <= 32'h0000_0000;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q <= ~w_have_d & ~bvalid_d;
            arready_q <= ~rvalid_d;
            if (aw_fire) awaddr_q <= AXI_REQ_I.awaddr;
            if (w_fire) wdata_q <= AXI_REQ_I.wdata;
            if (w_fire) wstrb_q <= AXI_REQ_I.wstrb;
            if (do_write) bresp_q <= w_mapped ? `PLCIO_RESP_OK : `PLCIO_RESP_ERR;
            if (ar_fire) rdata_q <= rd_data;
            if (ar_fire) rresp_q <= rd_hit ? `PLCIO_RESP_OK : `PLCIO_RESP_ERR;
        end
    end

    // software-written words; zero at reset, config words at their defaults
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < 4; i++) aout_q[i] <= `PLCIO_WORD_RST; // see RL22
            clear_q <= `PLCIO_WORD_RST; // see RL22
            run_q <= `PLCIO_WORD_RST;
            target_q <= `PLCIO_WORD_RST;
            feedbk_q <= `PLCIO_WORD_RST;
            pidrun_q <= `PLCIO_WORD_RST;
            pidact_q <= `PLCIO_PIDACT_RST;
            scale_q <= `PLCIO_SCALE_RST; // see RL7
            presc_q <= `PLCIO_PRESC_RST; // see RL8
            outsrc_q <= `PLCIO_OUTSRC_RST;
        end else begin
            if (we_aout) aout_q[aout_idx] <= merge16(aout_q[aout_idx], wd, ws);
            if (we_clear) clear_q <= merge16(clear_q, wd, ws);
            if (we_run) run_q <= merge16(run_q, wd, ws);
            if (we_target) target_q <= merge16(target_q, wd, ws);
            if (we_feedbk) feedbk_q <= merge16(feedbk_q, wd, ws);
            if (we_pidrun) pidrun_q <= merge16(pidrun_q, wd, ws);
            if (we_pidact) pidact_q <= merge16(pidact_q, wd, ws);
            if (we_scale) scale_q <= merge16(scale_q, wd, ws);
            if (we_presc) presc_q <= merge16(presc_q, wd, ws);
            if (we_outsrc) outsrc_q <= wd;
        end
    end

    // pins come from outside the clock; two stages before any use
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {pls_s1_q, pls_s2_q, pls_s3_q} <= 3'h0;
            {ext_s1_q, ext_s2_q} <= 2'h0;
        end else begin
            {pls_s1_q, pls_s2_q, pls_s3_q} <= {PULSE_PIN_I, pls_s1_q, pls_s2_q};
            {ext_s1_q, ext_s2_q} <= {EXT_PID_EN_PIN_I, ext_s1_q};
        end
    end

    // analog exchange with the terminals happens only at end of scan
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < 3; i++) ain_q[i] <= `PLCIO_WORD_RST;
            for (int i = 0; i < 4; i++) aterm_q[i] <= `PLCIO_WORD_RST;
            aplc_q <= 4'h0;
        end else if (SCAN_END_I) begin
            ain_q[0] <= AIN_A_I; // see RL2
            ain_q[1] <= AIN_B_I;
            ain_q[2] <= AIN_C_I;
            for (int i = 0; i < 4; i++) begin
                aplc_q[i] <= outsrc_q[8*i +: 8] == `PLCIO_SRC_PLC; // see RL4
                aterm_q[i] <= (outsrc_q[8*i +: 8] == `PLCIO_SRC_PLC) ?
                              aout_q[i] : 16'h0000; // see RL3
            end
        end
    end

    // pulse counter: count cycle tick, run gating and clear
    wire edge_seen = pls_s2_q & ~pls_s3_q;
    wire tick = cyc_q == 32'(CYCLE_CLKS - 1);
    wire cnt_run = run_q == 16'h0001; // see RL11
    wire cnt_clr = clear_q == 16'h0001; // see RL10
    wire [15:0] presc_eff = (presc_q > `PLCIO_SAMPLE_MAX) ?
                            `PLCIO_SAMPLE_MAX : presc_q; // see RL8
    wire [15:0] sample_d = scale(cnt_q, presc_eff, scale_q[2:0]); // see RL6
    wire [32:0] tot_sum = 33'(total_q) + 33'(sample_d);
    wire [31:0] total_d = (tot_sum > 33'(`PLCIO_TOTAL_MAX)) ?
                          `PLCIO_TOTAL_MAX : tot_sum[31:0];
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cyc_q <= 32'h0000_0000;
            cnt_q <= 16'h0000;
            sample_q <= 16'h0000;
            total_q <= 32'h0000_0000;
        end else begin
            cyc_q <= tick ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
            if (cnt_clr) begin
                cnt_q <= 16'h0000; // see RL10
                sample_q <= 16'h0000;
                total_q <= 32'h0000_0000;
            end else if (cnt_run) begin
                if (tick) begin
                    cnt_q <= {15'h0000, edge_seen};
                    sample_q <= sample_d; // see RL5
                    total_q <= total_d; // see RL9
                end else if (edge_seen && cnt_q != 16'hffff) begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
            // stopped: count, sample and total hold their last values while the cycle counter runs on, see RL21
        end
    end

    // pid operands, limited to their ranges before use
    plcio_pid_src_t src;
    assign src = pid_src(pidact_q); // see RL12
    wire fwd = pidact_q[0]; // see RL12
    wire signed [16:0] sp = clamp17(18'(signed'(target_q)),
                                    -`PLCIO_PCT_MAX, `PLCIO_PCT_MAX); // see RL15
    wire signed [16:0] pv = clamp17(18'(signed'(feedbk_q)),
                                    17'sh00000, `PLCIO_PCT_MAX); // see RL16
    // deviation mode takes the target word as error, see RL14 and RL17
    wire signed [17:0] dev = (src == PLCIO_PID_DEV) ? 18'(sp) :
                             18'(sp) - 18'(pv);
    wire signed [16:0] mv = clamp17(fwd ? -dev : dev,
                                    -`PLCIO_PCT_MAX, `PLCIO_PCT_MAX); // see RL20
    wire pid_go = pidrun_q == 16'h0001; // see RL19
    wire plc_pid = src != PLCIO_PID_EXT;
    wire no_apply = pidact_q == 16'h005a || pidact_q == 16'h005b ||
                    pidact_q == 16'h0064 || pidact_q == 16'h0065;

    // pid result is taken at end of scan like the analog exchange
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pidout_q <= 16'h0000;
            pid_en_q <= 1'b0;
            apply_q <= 1'b0;
        end else if (SCAN_END_I) begin
            pidout_q <= (plc_pid && pid_go) ? mv[15:0] : 16'h0000; // see RL18
            pid_en_q <= plc_pid ? pid_go : ext_s2_q; // see RL19
            apply_q <= plc_pid && pid_go && !no_apply; // see RL13
        end
    end

    // outputs, all straight from flip-flops
    assign AXI_RSP_O = '{awready: awready_q, wready: wready_q,
                         bvalid: bvalid_q, bresp: bresp_q,
                         arready: arready_q, rvalid: rvalid_q,
                         rdata: rdata_q, rresp: rresp_q};
    assign AOUT_METER_O = aterm_q[0];
    assign AOUT_MAIN_O = aterm_q[1];
    assign AOUT_OPT_A_O = aterm_q[2];
    assign AOUT_OPT_B_O = aterm_q[3];
    assign AOUT_PLC_O = aplc_q;
    assign PID_MV_O = pidout_q;
    assign PID_RUN_O = pid_en_q;
    assign PID_APPLY_O = apply_q;

    // checks on the block's own behaviour
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence scan_s; SCAN_END_I; endsequence
    sequence no_scan_s; !SCAN_END_I; endsequence

    ain_latch_a: assert property (scan_s |=> ain_q[0] == $past(AIN_A_I)) // see RL1
        else $error("analog input not taken at end of scan");
    ain_hold_a: assert property (no_scan_s |=> $stable(ain_q[2])) // see RL2
        else $error("analog input moved outside end of scan");
    aout_gate_a: assert property (scan_s // see RL4
        and outsrc_q[7:0] != 8'h07
        |=> AOUT_METER_O == 16'h0000 && !AOUT_PLC_O[0])
        else $error("meter output driven without source 7");
    aout_follow_a: assert property (scan_s // see RL3
        and outsrc_q[7:0] == 8'h07 |=> AOUT_METER_O == $past(aout_q[0]))
        else $error("meter output does not follow its register");
    sample_range_a: assert property (sample_q <= 16'h7fff // see RL5
        && tot_lo <= 16'h270f)
        else $error("pulse count outside its range");
    count_clear_a: assert property (cnt_clr |=> total_q == 32'h0 // see RL10
        && sample_q == 16'h0 && cnt_q == 16'h0)
        else $error("pulse counts not cleared");
    stop_hold_a: assert property (!cnt_run && !cnt_clr // see RL11
        |=> $stable(total_q) && $stable(sample_q))
        else $error("pulse counts changed while stopped");
    // small counts only, so the hundredfold product never saturates
    scale_cent_a: assert property (tick && cnt_run && !cnt_clr // see RL6
        && scale_q == 16'h0003 && presc_q == 16'h2710 && cnt_q < 16'h0100
        |=> sample_q == $past(cnt_q) * 16'h0064)
        else $error("sample not pulses times prescale over hundred");
    total_acc_a: assert property (tick && cnt_run && !cnt_clr // see RL9
        && total_q < 32'h0000_2710
        |=> total_q == $past(total_q) + 32'($past(sample_d)))
        else $error("sample not added to the pulse total");
    pid_range_a: assert property (signed'(pidout_q) <= 16'sh2710 && // see RL18
        signed'(pidout_q) >= -16'sh2710)
        else $error("pid result outside range");
    pid_stop_a: assert property (scan_s and !pid_go // see RL19
        |=> pidout_q == 16'h0000 && !PID_APPLY_O)
        else $error("pid result while stopped");
    pid_ignore_a: assert property (scan_s and pid_go // see RL17
        and src == PLCIO_PID_DEV and !fwd and target_q == 16'h4e20
        |=> pidout_q == 16'h2710)
        else $error("feedback used in deviation mode");

endmodule : plcio_top
`default_nettype wire

// *** inc/plcio_regs.svh ***
// register offsets, reset values, limits and timing of the special registers
`ifndef PLCIO_REGS_SVH
`define PLCIO_REGS_SVH

`define PLCIO_AIN_OFS 8'h00
`define PLCIO_AOUT_OFS 8'h0c
`define PLCIO_SAMPLE_OFS 8'h1c
`define PLCIO_TOT_LO_OFS 8'h20
`define PLCIO_TOT_HI_OFS 8'h24
`define PLCIO_CLEAR_OFS 8'h28
`define PLCIO_RUN_OFS 8'h2c
`define PLCIO_TARGET_OFS 8'h30
`define PLCIO_FEEDBK_OFS 8'h34
`define PLCIO_PIDOUT_OFS 8'h38
`define PLCIO_PIDRUN_OFS 8'h3c
`define PLCIO_PIDACT_OFS 8'h40
`define PLCIO_SCALE_OFS 8'h44
`define PLCIO_PRESC_OFS 8'h48
`define PLCIO_OUTSRC_OFS 8'h4c

`define PLCIO_WORD_RST 16'h0000
`define PLCIO_PIDACT_RST 16'h000a
`define PLCIO_SCALE_RST 16'h0000
`define PLCIO_PRESC_RST 16'h0001
`define PLCIO_OUTSRC_RST 32'h0000_0000

`define PLCIO_SRC_PLC 8'h07
`define PLCIO_SAMPLE_MAX 16'h7fff
`define PLCIO_LOW_MOD 32'h0000_2710
`define PLCIO_TOTAL_MAX 32'h2710_fe0f
`define PLCIO_PCT_MAX 17'sh02710
`define PLCIO_RESP_OK 2'h0
`define PLCIO_RESP_ERR 2'h2

`define PLCIO_CLK_NS 20
`define PLCIO_CYCLE_US 1000
`define PLCIO_CYCLE_CLKS (`PLCIO_CYCLE_US * 1000 / `PLCIO_CLK_NS)

`endif

// *** inc/plcio_pkg.sv ***
// bus carrier structs and pid source type of the special register block
`default_nettype none
package plcio_pkg;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } plcio_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } plcio_axi_rsp_t;

    typedef enum logic [1:0] {
        PLCIO_PID_EXT = 2'b00,
        PLCIO_PID_DEV = 2'b01,
        PLCIO_PID_SPPV = 2'b10
    } plcio_pid_src_t;

endpackage : plcio_pkg
`default_nettype wire

// *** sim/plc_io_special_registers_tb_top.sv ***
// self-checking bench of the special register block over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "plcio_regs.svh"
module plc_io_special_registers_tb_top;
    import plcio_pkg::*;
    localparam int unsigned CYC = 16; // short count cycle keeps the run brief
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scan = 1'b0;
    logic pin = 1'b0;
    logic pen = 1'b0;
    logic xen = 1'b1;
    logic [1:0] pc = 2'h0;
    logic [15:0] ao_m, ao_a, ao_oa, ao_ob, mv;
    logic [3:0] plc;
    logic run, apply;
    plcio_axi_req_t req = '{wstrb: 4'hf, bready: 1'b1, rready: 1'b1, default: '0};
    plcio_axi_rsp_t rsp;
    int num_errors = 0;
    int samples_checked = 0;
    logic [15:0] exp_s [6] = '{16'h0004, 16'h7fff, 16'h0fa0, 16'h0190, 16'h0028, 16'h0004};
    always #10 clk = ~clk;
    // one pin edge every four clocks gives exactly four per count cycle
    always @(posedge clk) begin
        pc <= pc + 2'h1;
        pin <= pen & pc[1];
    end
    plcio_top #(.CYCLE_CLKS(CYC)) dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .AXI_REQ_I(req), .AXI_RSP_O(rsp), .SCAN_END_I(scan),
        .AIN_A_I(16'h0123), .AIN_B_I(16'h0000), .AIN_C_I(16'h03e8),
        .PULSE_PIN_I(pin), .EXT_PID_EN_PIN_I(xen), .AOUT_METER_O(ao_m),
        .AOUT_MAIN_O(ao_a), .AOUT_OPT_A_O(ao_oa), .AOUT_OPT_B_O(ao_ob),
        .AOUT_PLC_O(plc), .PID_MV_O(mv), .PID_RUN_O(run), .PID_APPLY_O(apply));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // bready and rready stay high, so the answer edge ends each access
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        chk($sformatf("bresp %h", a), 32'(r), 32'(rsp.bresp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        chk($sformatf("rdata %h", a), e, rsp.rdata);
        chk($sformatf("rresp %h", a), 32'(r), 32'(rsp.rresp));
    endtask : rd
    // one end-of-scan strobe, then let its updates land
    task automatic tick;
        @(posedge clk);
        scan <= 1'b1;
        @(posedge clk);
        scan <= 1'b0;
        #1;
    endtask : tick
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`PLCIO_PIDACT_OFS, 32'h0000_000a, `PLCIO_RESP_OK);
        rd(`PLCIO_PRESC_OFS, 32'h0000_0001, `PLCIO_RESP_OK);
        rd(`PLCIO_SCALE_OFS, 32'h0, `PLCIO_RESP_OK);
        rd(`PLCIO_AOUT_OFS, 32'h0, `PLCIO_RESP_OK);
        $display("test reset values done");
        rd(`PLCIO_AIN_OFS, 32'h0, `PLCIO_RESP_OK);
        tick();
        rd(`PLCIO_AIN_OFS, 32'h0123, `PLCIO_RESP_OK);
        rd(8'h08, 32'h03e8, `PLCIO_RESP_OK);
        wr(`PLCIO_AIN_OFS, 32'h5, `PLCIO_RESP_ERR);
        rd(8'h80, 32'h0, `PLCIO_RESP_ERR);
        $display("test analog input done");
        wr(`PLCIO_AOUT_OFS, 32'h0155, `PLCIO_RESP_OK);
        wr(8'h10, 32'h0222, `PLCIO_RESP_OK);
        wr(8'h18, 32'h0333, `PLCIO_RESP_OK);
        wr(`PLCIO_OUTSRC_OFS, 32'h0700_0307, `PLCIO_RESP_OK);
        chk("meter held", 32'h0, 32'(ao_m));
        tick();
        chk("meter", 32'h0155, 32'(ao_m));
        chk("main", 32'h0, 32'(ao_a));
        chk("source", 32'h9, 32'(plc));
        chk("option a", 32'h0, 32'(ao_oa));
        chk("option b", 32'h0333, 32'(ao_ob));
        $display("test analog output done");
        wr(`PLCIO_PIDRUN_OFS, 32'h1, `PLCIO_RESP_OK);
        wr(`PLCIO_PIDACT_OFS, 32'h46, `PLCIO_RESP_OK);
        wr(`PLCIO_TARGET_OFS, 32'h4e20, `PLCIO_RESP_OK);
        wr(`PLCIO_FEEDBK_OFS, 32'h0bb8, `PLCIO_RESP_OK);
        tick();
        chk("mv 70", 32'h2710, 32'(mv));
        chk("run", 32'h1, 32'(run));
        chk("apply", 32'h1, 32'(apply));
        rd(`PLCIO_PIDOUT_OFS, 32'h2710, `PLCIO_RESP_OK);
        wr(`PLCIO_PIDACT_OFS, 32'h47, `PLCIO_RESP_OK);
        tick();
        chk("mv 71", 32'hd8f0, 32'(mv));
        wr(`PLCIO_PIDACT_OFS, 32'h50, `PLCIO_RESP_OK);
        wr(`PLCIO_TARGET_OFS, 32'h1388, `PLCIO_RESP_OK);
        tick();
        chk("mv 80", 32'h07d0, 32'(mv));
        wr(`PLCIO_PIDACT_OFS, 32'h65, `PLCIO_RESP_OK);
        tick();
        chk("mv 101", 32'hf830, 32'(mv));
        chk("apply 101", 32'h0, 32'(apply));
        wr(`PLCIO_PIDRUN_OFS, 32'h0, `PLCIO_RESP_OK);
        tick();
        chk("mv stop", 32'h0, 32'(mv));
        chk("run stop", 32'h0, 32'(run));
        wr(`PLCIO_PIDACT_OFS, 32'h0a, `PLCIO_RESP_OK);
        tick();
        chk("run ext", 32'h1, 32'(run));
        // pin low needs two sync stages before the strobe sees it
        @(posedge clk);
        xen <= 1'b0;
        repeat (2) @(posedge clk);
        tick();
        chk("run pin low", 32'h0, 32'(run));
        $display("test pid done");
        @(posedge clk);
        pen <= 1'b1;
        wr(`PLCIO_PRESC_OFS, 32'h2710, `PLCIO_RESP_OK);
        wr(`PLCIO_RUN_OFS, 32'h1, `PLCIO_RESP_OK);
        // every scaling code in turn, four pulses per count cycle
        for (int i = 0; i < 6; i++) begin
            wr(`PLCIO_SCALE_OFS, 32'(i), `PLCIO_RESP_OK);
            repeat (3 * CYC) @(posedge clk);
            rd(`PLCIO_SAMPLE_OFS, 32'(exp_s[i]), `PLCIO_RESP_OK);
        end
        wr(`PLCIO_RUN_OFS, 32'h0, `PLCIO_RESP_OK);
        wr(`PLCIO_SCALE_OFS, 32'h1, `PLCIO_RESP_OK);
        repeat (3 * CYC) @(posedge clk);
        rd(`PLCIO_SAMPLE_OFS, 32'h4, `PLCIO_RESP_OK);
        wr(`PLCIO_CLEAR_OFS, 32'h1, `PLCIO_RESP_OK);
        repeat (2) @(posedge clk);
        rd(`PLCIO_SAMPLE_OFS, 32'h0, `PLCIO_RESP_OK);
        rd(`PLCIO_TOT_LO_OFS, 32'h0, `PLCIO_RESP_OK);
        rd(`PLCIO_TOT_HI_OFS, 32'h0, `PLCIO_RESP_OK);
        $display("test pulse counter done");
        end_of_test();
    end
endmodule : plc_io_special_registers_tb_top
`default_nettype wire
